// [rtl/rbd_pkg.sv]
// package for the rotate and bcd digit unit: opcode fields, cycle counts, carriers
// assumes a 16-bit instruction word and flags held by the surrounding processor
package rbd_pkg;
   // first-word opcode fields
   localparam logic [6:0] ROT_GROUP = 7'h59;      // 10 11001
   localparam logic [7:0] DIG_LEFT_OP = 8'hbe;    // 10 111110
   localparam logic [7:0] DIG_RIGHT_OP = 8'hbc;   // 10 111100
   localparam logic [1:0] SUB_RL = 2'h0;
   localparam logic [1:0] SUB_RR = 2'h1;
   localparam logic [1:0] SUB_RLC = 2'h2;
   localparam logic [1:0] SUB_RRC = 2'h3;
   // field positions in the instruction word
   localparam int OP_HI = 15;
   localparam int GRP_LO = 9;
   localparam int OP8_LO = 8;
   localparam int SIZE_BIT = 8;
   localparam int SUB_HI = 3;
   localparam int SUB_LO = 2;
   localparam int CNT_BIT = 1;
   localparam int ZERO_BIT = 0;
   // execution lengths in clock cycles
   localparam logic [3:0] CYC_ROT1 = 4'h6;
   localparam logic [3:0] CYC_ROT2 = 4'h7;
   localparam logic [3:0] CYC_DIG = 4'h9;

   typedef enum {RBD_IDLE, RBD_BUSY} rbd_state_t;

   // flags as seen by the unit
   typedef struct packed {
      logic carry;
      logic zero;
      logic sign;
      logic overflow;
      logic dec_adjust;
      logic half_carry;
   } rbd_flags_t;

   // operation request from decoder and register file
   typedef struct packed {
      logic [15:0] instr;
      logic [15:0] operand;
      logic [7:0] link_byte;
      logic [7:0] src_byte;
   } rbd_req_t;
endpackage : rbd_pkg

// [rtl/rbd_unit.sv]
// rotate and bcd digit unit: executes single-register rotates and digit rotates
// assumes decoder gives one-cycle start with instruction and operands on the same clock
// Overview of operation
// - left through carry: old carry enters bit 0
// - omitted count means rotate by one
// - carry out is last bit leaving msb
// - zero flag set when rotated result zero
// - sign flag copies result top bit
// - overflow on top-bit change; others unchanged
// - decode left through carry, sub field 10
// - count bit zero one, one two
// - rotate takes six or seven cycles
// - decode plain right rotate, sub field 01
// - right rotate: bit 0 to msb, carry
// - decode right through carry, sub field 11
// - right through carry: carry into msb
// - digit left nibble movement, opcode 10111110
// - digit right nibble movement
// - digit: carry kept, zero from link
// - digit: sign free, others unchanged
// - decode digit right; digits take nine cycles
module rbd_unit (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input rbd_pkg::rbd_req_t req,
   input rbd_pkg::rbd_flags_t flags_in,
   output logic busy,
   output logic done,
   output logic illegal,
   output logic [15:0] result,
   output logic [7:0] link_result,
   output logic [7:0] src_result,
   output logic writes_word,
   output logic digit_op,
   output rbd_pkg::rbd_flags_t flags_out
);

   // one rotate step at the given width; in_bit is the bit entering the far end
   function automatic logic [15:0] rot_left(input logic [15:0] v, input logic in_bit,
                                            input logic is_word);
      logic [15:0] r;
      r = {v[14:0], in_bit};
      if (!is_word) begin
         r[15:8] = 8'h00;
      end
      return r;
   endfunction : rot_left

   function automatic logic [15:0] rot_right(input logic [15:0] v, input logic in_bit,
                                             input logic is_word);
      logic [15:0] r;
      r = {1'b0, v[15:1]};
      if (is_word) begin
         r[15] = in_bit;
      end else begin
         r[15:8] = 8'h00;
         r[7] = in_bit;
      end
      return r;
   endfunction : rot_right

   function automatic logic top_bit(input logic [15:0] v, input logic is_word);
      return is_word ? v[15] : v[7];
   endfunction : top_bit

   // decode
   localparam int OP_HI_W = rbd_pkg::OP_HI;
   localparam int GRP_LO_W = rbd_pkg::GRP_LO;
   wire [15:0] ins = req.instr;
   wire is_rot = (ins[OP_HI_W:GRP_LO_W] == rbd_pkg::ROT_GROUP)
                 && !ins[rbd_pkg::ZERO_BIT];
   wire [1:0] sub = ins[rbd_pkg::SUB_HI:rbd_pkg::SUB_LO];
   wire is_word = ins[rbd_pkg::SIZE_BIT];
   wire two_steps = ins[rbd_pkg::CNT_BIT];
   wire is_dl = (ins[OP_HI_W:rbd_pkg::OP8_LO] == rbd_pkg::DIG_LEFT_OP);
   wire is_dr = (ins[OP_HI_W:rbd_pkg::OP8_LO] == rbd_pkg::DIG_RIGHT_OP);
   wire is_dig = is_dl || is_dr;

   // one and two bitwise steps of each rotate kind
   wire [15:0] opnd = is_word ? req.operand : {8'h00, req.operand[7:0]};
   logic [15:0] s1_val;
   logic s1_c;
   logic [15:0] s2_val;
   logic s2_c;
   logic [15:0] rot_val;
   logic rot_c;
   always_comb begin
      s1_val = opnd;
      s1_c = flags_in.carry;
      s2_val = opnd;
      s2_c = flags_in.carry;
      case (sub)
         rbd_pkg::SUB_RL: begin
            s1_val = rot_left(opnd, top_bit(opnd, is_word), is_word);
            s1_c = top_bit(opnd, is_word);
            s2_val = rot_left(s1_val, top_bit(s1_val, is_word), is_word);
            s2_c = top_bit(s1_val, is_word);
         end
         rbd_pkg::SUB_RLC: begin
            s1_val = rot_left(opnd, flags_in.carry, is_word);
            s1_c = top_bit(opnd, is_word);
            s2_val = rot_left(s1_val, s1_c, is_word);
            s2_c = top_bit(s1_val, is_word);
         end
         rbd_pkg::SUB_RR: begin
            s1_val = rot_right(opnd, opnd[0], is_word);
            s1_c = opnd[0];
            s2_val = rot_right(s1_val, s1_val[0], is_word);
            s2_c = s1_val[0];
         end
         default: begin
            s1_val = rot_right(opnd, flags_in.carry, is_word);
            s1_c = opnd[0];
            s2_val = rot_right(s1_val, s1_c, is_word);
            s2_c = s1_val[0];
         end
      endcase
      rot_val = two_steps ? s2_val : s1_val;
      rot_c = two_steps ? s2_c : s1_c;
   end

   // sign changed if the top bit differed at any point of the rotation
   wire top0 = top_bit(opnd, is_word);
   wire top1 = top_bit(s1_val, is_word);
   wire top2 = top_bit(s2_val, is_word);
   wire sign_chg = two_steps ? ((top0 != top1) || (top1 != top2)) : (top0 != top1);

   // digit nibble moves
   wire [7:0] lnk = req.link_byte;
   wire [7:0] srcb = req.src_byte;
   wire [7:0] dl_link = {lnk[7:4], srcb[7:4]};
   wire [7:0] dl_src = {srcb[3:0], lnk[3:0]};
   wire [7:0] dr_link = {lnk[7:4], srcb[3:0]};
   wire [7:0] dr_src = {lnk[3:0], srcb[7:4]};
   wire [7:0] dig_link = is_dl ? dl_link : dr_link;
   wire [7:0] dig_src = is_dl ? dl_src : dr_src;

   // flag results
   rbd_pkg::rbd_flags_t rot_flags;
   rbd_pkg::rbd_flags_t dig_flags;
   always_comb begin
      rot_flags = flags_in;
      rot_flags.carry = rot_c;
      rot_flags.zero = (rot_val == 16'h0000);
      rot_flags.sign = top_bit(rot_val, is_word);
      rot_flags.overflow = sign_chg;
      dig_flags = flags_in;
      dig_flags.zero = (dig_link == 8'h00);
      dig_flags.sign = dig_link[7];
   end

   // sequencer state, declared ahead of its readers
   rbd_pkg::rbd_state_t state_r;
   rbd_pkg::rbd_state_t state_nxt;
   logic busy_r;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;

   // cycle length of the accepted operation
   wire [3:0] op_len = is_dig ? rbd_pkg::CYC_DIG
                       : (two_steps ? rbd_pkg::CYC_ROT2 : rbd_pkg::CYC_ROT1);
   wire accept = start && !busy_r;
   wire legal = is_rot || is_dig;
   wire last = (state_r == rbd_pkg::RBD_BUSY) && (cnt_r == 4'h1);

   // sequencing: result appears after the documented cycle count
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         rbd_pkg::RBD_IDLE: begin
            if (start && legal) begin
               state_nxt = rbd_pkg::RBD_BUSY;
               cnt_nxt = op_len - 4'h1;
            end
         end
         rbd_pkg::RBD_BUSY: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               state_nxt = rbd_pkg::RBD_IDLE;
            end
         end
         default: begin
            state_nxt = rbd_pkg::RBD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= rbd_pkg::RBD_IDLE;
         cnt_r <= 4'h0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         busy_r <= (state_nxt == rbd_pkg::RBD_BUSY);
      end
   end

   // captured results, released with done
   logic [15:0] res_r;
   logic [7:0] lres_r;
   logic [7:0] sres_r;
   logic word_r;
   logic dig_r;
   rbd_pkg::rbd_flags_t fl_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         res_r <= 16'h0000;
         lres_r <= 8'h00;
         sres_r <= 8'h00;
         word_r <= 1'b0;
         dig_r <= 1'b0;
         fl_r <= '0;
      end else if (accept && legal) begin
         res_r <= rot_val;
         lres_r <= dig_link;
         sres_r <= dig_src;
         word_r <= is_word && !is_dig;
         dig_r <= is_dig;
         fl_r <= is_dig ? dig_flags : rot_flags;
      end
   end

   // outputs from flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         done <= 1'b0;
         illegal <= 1'b0;
         result <= 16'h0000;
         link_result <= 8'h00;
         src_result <= 8'h00;
         writes_word <= 1'b0;
         digit_op <= 1'b0;
         flags_out <= '0;
      end else begin
         busy <= (state_nxt == rbd_pkg::RBD_BUSY);
         done <= last;
         illegal <= accept && !legal;
         if (last) begin
            result <= res_r;
            link_result <= lres_r;
            src_result <= sres_r;
            writes_word <= word_r;
            digit_op <= dig_r;
            flags_out <= fl_r;
         end
      end
   end
endmodule : rbd_unit

// [tb/rbd_unit_properties.sv]
// checker on the top ports of the rotate and bcd digit unit
// assumes one clk domain and the async active-low reset_n
module rbd_unit_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire rbd_pkg::rbd_req_t req,
   input wire rbd_pkg::rbd_flags_t flags_in,
   input wire logic busy,
   input wire logic done,
   input wire logic illegal,
   input wire logic [15:0] result,
   input wire logic [7:0] link_result,
   input wire logic [7:0] src_result,
   input wire logic writes_word,
   input wire logic digit_op,
   input wire rbd_pkg::rbd_flags_t flags_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // request decode at the taking edge
   wire take = start && !busy;
   wire rot = req.instr[15:9] == rbd_pkg::ROT_GROUP && !req.instr[0];
   wire dig = req.instr[15:8] == rbd_pkg::DIG_LEFT_OP || req.instr[15:8] == rbd_pkg::DIG_RIGHT_OP;
   sequence s_six; ##1 !done [*5] ##1 done; endsequence
   sequence s_seven; ##1 !done [*6] ##1 done; endsequence
   sequence s_nine; ##1 !done [*8] ##1 done; endsequence
   property p_rot1; take && rot && !req.instr[1] |-> s_six; endproperty
   a_rot1: assert property (p_rot1) else $error("short rotate late");
   property p_rot2; take && rot && req.instr[1] |-> s_seven; endproperty
   a_rot2: assert property (p_rot2) else $error("long rotate late");
   property p_dig; take && dig |-> s_nine; endproperty
   a_dig: assert property (p_dig) else $error("digit rotate late");
   property p_busy; take && (rot || dig) |=> busy; endproperty
   a_busy: assert property (p_busy) else $error("busy missing");
   property p_ill; take && !rot && !dig |=> illegal && !busy; endproperty
   a_ill: assert property (p_ill) else $error("illegal missing");
   property p_zero; done && !digit_op |-> flags_out.zero == (result == 16'h0000); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_sign;
      done && !digit_op |-> flags_out.sign == (writes_word ? result[15] : result[7]);
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag wrong");
   property p_byte; done && !digit_op && !writes_word |-> result[15:8] == 8'h00; endproperty
   a_byte: assert property (p_byte) else $error("byte upper set");
   property p_dzero; done && digit_op |-> flags_out.zero == (link_result == 8'h00); endproperty
   a_dzero: assert property (p_dzero) else $error("digit zero wrong");
   property p_dkeep;
      take && dig |-> ##9 link_result[7:4] == $past(req.link_byte[7:4], 9) &&
         flags_out.carry == $past(flags_in.carry, 9);
   endproperty
   a_dkeep: assert property (p_dkeep) else $error("digit kept bits wrong");
endmodule : rbd_unit_properties

bind rbd_unit rbd_unit_properties u_props (.clk(clk), .reset_n(reset_n), .start(start),
   .req(req), .flags_in(flags_in), .busy(busy), .done(done), .illegal(illegal),
   .result(result), .link_result(link_result), .src_result(src_result),
   .writes_word(writes_word), .digit_op(digit_op), .flags_out(flags_out));

// [tb/rbd_unit_tb.sv]
// self-checking bench for the rotate and bcd digit unit
// assumes the unit alone, inputs driven at the falling edge
module rbd_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, start, busy, done, illegal, writes_word, digit_op, co, v;
   rbd_pkg::rbd_req_t req;
   rbd_pkg::rbd_flags_t flags_in, flags_out, fi;
   logic [15:0] result, r;
   logic [7:0] link_result, src_result, lk, sr, el, es;
   logic [15:0] ops [4] = '{16'h800f, 16'h00dd, 16'h0100, 16'h8001};
   logic [15:0] dps [3] = '{16'h0500, 16'ha51e, 16'h3c96};
   int n_errors = 0;
   int checks = 0;
   int n;
   `define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
   rbd_unit dut (.clk(clk), .reset_n(reset_n), .start(start), .req(req), .flags_in(flags_in),
      .busy(busy), .done(done), .illegal(illegal), .result(result),
      .link_result(link_result), .src_result(src_result), .writes_word(writes_word),
      .digit_op(digit_op), .flags_out(flags_out));
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic tally_and_finish;
      if (n_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   // one request; counts edges to done, pokes a refused start while busy
   task automatic run(input logic [15:0] ins, input logic [15:0] op, input logic [7:0] l,
         input logic [7:0] s, input rbd_pkg::rbd_flags_t f, input logic poke);
      start = 1'b1;
      req = '{ins, op, l, s};
      flags_in = f;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         start = poke && n == 2;
         if (poke) req = '{16'h0000, ~op, ~l, ~s};
      end while (done !== 1'b1 && illegal !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         tally_and_finish;
      end
   endtask : run
   // reference rotate, step by step at the chosen width
   task automatic ref_rot(input int sub, input int w, input int c, input logic [15:0] op,
         input logic ci);
      int m;
      logic t;
      m = w ? 15 : 7;
      r = w ? op : {8'h00, op[7:0]};
      co = ci;
      v = 1'b0;
      for (int i = 0; i <= c; i++) begin
         t = co;
         co = sub[0] ? r[0] : r[m];
         r = sub[0] ? r >> 1 : r << 1;
         if (!sub[0]) r[0] = sub == 2 ? t : co;
         else r[m] = sub == 1 ? co : t;
         if (!w) r[15:8] = 8'h00;
         if (r[m] != op[m]) v = 1'b1;
      end
   endtask : ref_rot
   initial begin
      reset_n = 1'b0;
      start = 1'b0;
      req = '0;
      flags_in = '0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      // plain left, right, left through carry, right through carry
      for (int sub = 0; sub < 4; sub++)
         for (int w = 0; w < 2; w++)
            for (int c = 0; c < 2; c++)
               for (int k = 0; k < 8; k++) begin
                  ref_rot(sub, w, c, ops[k/2], k[0]);
                  fi = '{k[0], 1'b0, 1'b0, 1'b0, k[0], ~k[0]};
                  run({rbd_pkg::ROT_GROUP, 1'(w), 4'h3, 2'(sub), 1'(c), 1'b0}, ops[k/2],
                     8'h00, 8'h00, fi, k == 3);
                  `CHK(n, c ? 7 : 6)
                  `CHK(result, r)
                  `CHK(flags_out.carry, co)
                  `CHK(flags_out.zero, r == 16'h0000)
                  `CHK(flags_out.sign, w ? r[15] : r[7])
                  `CHK(flags_out.overflow, v)
                  `CHK({flags_out.dec_adjust, flags_out.half_carry}, {k[0], ~k[0]})
                  `CHK(writes_word, 1'(w))
               end
      // digit rotates left and right
      for (int d = 0; d < 2; d++)
         for (int k = 0; k < 3; k++) begin
            {lk, sr} = dps[k];
            el = d ? {lk[7:4], sr[3:0]} : {lk[7:4], sr[7:4]};
            es = d ? {lk[3:0], sr[7:4]} : {sr[3:0], lk[3:0]};
            fi = '{k[0], 1'b0, 1'b0, ~k[0], k[0], k[0]};
            run({d ? rbd_pkg::DIG_RIGHT_OP : rbd_pkg::DIG_LEFT_OP, 8'h12}, 16'h0000, lk, sr,
               fi, k == 1);
            `CHK(n, 9)
            `CHK({link_result, src_result}, {el, es})
            `CHK(flags_out.zero, el == 8'h00)
            `CHK(flags_out.carry, k[0])
            `CHK(flags_out[2:0], {~k[0], k[0], k[0]})
            `CHK(digit_op, 1'b1)
         end
      // unknown encoding is refused at once
      run(16'h0000, 16'h1234, 8'h00, 8'h00, fi, 1'b0);
      `CHK({n, illegal}, {32'd1, 1'b1})
      tally_and_finish;
   end
endmodule : rbd_unit_tb
